//--- rtl/fsl_led_top.sv
// fieldbus status led indicator with apb register slave
//
// Overview of operation
// [RULE1] The error led is dark when healthy and otherwise shows flicker, blink, single flash, double flash or steady.
// [RULE2] A boot error forces the comm state to INIT, sets the change field to 0x01 and flickers the error led.
// [RULE3] An application-initiated state change sets the change field to 0x01 and single-flashes the error led.
// [RULE4] An application watchdog expiry double-flashes the error led.
// [RULE5] A process data interface watchdog expiry lights the error led steadily.
// [RULE6] In INIT the run led is dark.
// [RULE7] In PRE-OPERATIONAL the run led blinks.
// [RULE8] In SAFE-OPERATIONAL the run led single-flashes.
// [RULE9] In OPERATIONAL the run led is lit.
// [RULE10] Before INIT is first reached and in BOOTSTRAP the run led flickers.
// [RULE11] The alias address takes its low digit from one switch and its high digit from the other.
// [RULE12] Simultaneous errors show the most severe, process data interface watchdog first, with fixed parameterised periods.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "fsl_consts.svh"
module fsl_led_top #(
	parameter int TICK_CYCLES = `FSL_TICK_MS * `FSL_CLK_KHZ
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [`FSL_ADDR_W-1:0] i_paddr,
	input wire logic [`FSL_DATA_W-1:0] i_pwdata,
	output logic [`FSL_DATA_W-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_boot_done,
	input wire fsl_pkg::fsl_err_evt_t i_err_evt,
	input wire logic [`FSL_ST_CODE_W-1:0] i_unsol_state,
	input wire logic [`FSL_DIGIT_W-1:0] i_alias_low_digit_switch,
	input wire logic [`FSL_DIGIT_W-1:0] i_alias_high_digit_switch,
	output logic o_error_led,
	output logic o_run_led,
	output logic [`FSL_ALIAS_W-1:0] o_alias,
	output logic o_irq
);
	import fsl_pkg::*;

	function automatic logic code_ok(input logic [`FSL_ST_CODE_W-1:0] code);
		code_ok = (code == `FSL_CODE_INIT) || (code == `FSL_CODE_PREOP) || (code == `FSL_CODE_SAFEOP) ||
			(code == `FSL_CODE_OP) || (code == `FSL_CODE_BOOT);
	endfunction : code_ok

	function automatic fsl_comm_state_t code_to_state(input logic [`FSL_ST_CODE_W-1:0] code);
		case (code)
			`FSL_CODE_PREOP: code_to_state = FSL_ST_PREOP;
			`FSL_CODE_SAFEOP: code_to_state = FSL_ST_SAFEOP;
			`FSL_CODE_OP: code_to_state = FSL_ST_OP;
			`FSL_CODE_BOOT: code_to_state = FSL_ST_BOOT;
			default: code_to_state = FSL_ST_INIT;
		endcase
	endfunction : code_to_state

	function automatic logic [`FSL_ST_CODE_W-1:0] state_to_code(input fsl_comm_state_t st);
		case (st)
			FSL_ST_INIT: state_to_code = `FSL_CODE_INIT;
			FSL_ST_PREOP: state_to_code = `FSL_CODE_PREOP;
			FSL_ST_SAFEOP: state_to_code = `FSL_CODE_SAFEOP;
			FSL_ST_OP: state_to_code = `FSL_CODE_OP;
			FSL_ST_BOOT: state_to_code = `FSL_CODE_BOOT;
			default: state_to_code = `FSL_CODE_STARTUP;
		endcase
	endfunction : state_to_code

	fsl_waves_t waves;

	fsl_pattern_gen #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_pattern_gen (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.o_waves(waves)
	);

	// apb decode: pready is raised for the access phase only, so every transfer takes two cycles
	logic apb_setup;
	logic apb_access;
	logic wr_en;
	logic hit_ctrl;
	logic hit_al;
	logic hit_err;
	logic hit_mask;
	logic hit_alias;
	logic addr_mapped;
	logic [`FSL_DATA_W-1:0] rd_mux;

	assign apb_setup = i_psel & ~i_penable;
	assign apb_access = i_psel & i_penable & o_pready;
	assign wr_en = apb_access & i_pwrite & ~o_pslverr;
	assign hit_ctrl = (i_paddr == `FSL_OFF_CTRL);
	assign hit_al = (i_paddr == `FSL_OFF_AL_STATUS);
	assign hit_err = (i_paddr == `FSL_OFF_ERR_STAT);
	assign hit_mask = (i_paddr == `FSL_OFF_ERR_MASK);
	assign hit_alias = (i_paddr == `FSL_OFF_ALIAS);
	assign addr_mapped = hit_ctrl | hit_al | hit_err | hit_mask | hit_alias;

	fsl_comm_state_t comm_state;
	fsl_comm_state_t next_comm_state;
	logic [7:0] al_change;
	logic [7:0] next_al_change;
	logic [`FSL_ERR_W-1:0] err_stat;
	logic [`FSL_ERR_W-1:0] next_err_stat;
	logic [`FSL_ERR_W-1:0] err_mask;
	logic [`FSL_ERR_W-1:0] err_w1c;
	logic [`FSL_ST_CODE_W-1:0] wr_code;
	logic ctrl_wr;
	logic next_error_led;
	logic next_run_led;

	assign wr_code = i_pwdata[`FSL_ST_CODE_LSB +: `FSL_ST_CODE_W];
	// requests are refused until the device has left start-up on its own
	assign ctrl_wr = wr_en & hit_ctrl & (comm_state != FSL_ST_STARTUP) & code_ok(wr_code);
	assign err_w1c = (wr_en & hit_err) ? i_pwdata[`FSL_ERR_W-1:0] : '0;

	// boot error beats an unsolicited change, which beats a software request
	assign next_comm_state =
		i_err_evt.boot ? FSL_ST_INIT : // RULE2
		(i_err_evt.unsol && code_ok(i_unsol_state)) ? code_to_state(i_unsol_state) : // RULE3
		ctrl_wr ? code_to_state(wr_code) :
		(comm_state == FSL_ST_STARTUP && i_boot_done) ? FSL_ST_INIT :
		comm_state;

	// a new software request acknowledges the change field; a same-cycle event still sets it
	assign next_al_change =
		(i_err_evt.boot || i_err_evt.unsol) ? `FSL_AL_CHANGE_ERR : // RULE2 RULE3
		ctrl_wr ? `FSL_AL_CHANGE_NONE :
		al_change;

	// sticky: set wins over write-one-to-clear
	assign next_err_stat = (err_stat & ~err_w1c) | i_err_evt;

	assign rd_mux =
		hit_ctrl ? {{(`FSL_DATA_W - `FSL_ST_CODE_W){1'b0}}, state_to_code(comm_state)} :
		hit_al ? {{(`FSL_DATA_W - 16){1'b0}}, al_change, {(8 - `FSL_ST_CODE_W){1'b0}}, state_to_code(comm_state)} :
		hit_err ? {{(`FSL_DATA_W - `FSL_ERR_W){1'b0}}, err_stat} :
		hit_mask ? {{(`FSL_DATA_W - `FSL_ERR_W){1'b0}}, err_mask} :
		hit_alias ? {{(`FSL_DATA_W - `FSL_ALIAS_W){1'b0}}, o_alias} :
		'0;

	// most severe error wins the error led
	assign next_error_led =
		err_stat[`FSL_ERR_PROC_DATA_IF_WD] ? 1'b1 : // RULE5 RULE12
		err_stat[`FSL_ERR_APP_WD] ? waves.dflash : // RULE4
		err_stat[`FSL_ERR_UNSOL] ? waves.sflash : // RULE3
		err_stat[`FSL_ERR_CFG] ? waves.blink : // RULE1
		err_stat[`FSL_ERR_BOOT] ? waves.flicker : // RULE2
		1'b0; // RULE1

	assign next_run_led =
		(comm_state == FSL_ST_INIT) ? 1'b0 : // RULE6
		(comm_state == FSL_ST_PREOP) ? waves.blink : // RULE7
		(comm_state == FSL_ST_SAFEOP) ? waves.sflash : // RULE8
		(comm_state == FSL_ST_OP) ? 1'b1 : // RULE9
		waves.flicker; // RULE10

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= '0;
		end else begin
			o_pready <= apb_setup;
			o_pslverr <= apb_setup & ~addr_mapped;
			o_prdata <= (apb_setup & ~i_pwrite) ? rd_mux : '0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			comm_state <= FSL_ST_STARTUP;
			al_change <= `FSL_AL_CHANGE_NONE;
			err_stat <= `FSL_ERR_RST;
			err_mask <= `FSL_MASK_RST;
		end else begin
			comm_state <= next_comm_state;
			al_change <= next_al_change;
			err_stat <= next_err_stat;
			err_mask <= (wr_en & hit_mask) ? i_pwdata[`FSL_ERR_W-1:0] : err_mask;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_error_led <= 1'b0;
			o_run_led <= 1'b0;
			o_alias <= '0;
			o_irq <= 1'b0;
		end else begin
			o_error_led <= next_error_led;
			o_run_led <= next_run_led;
			o_alias <= {i_alias_high_digit_switch, i_alias_low_digit_switch}; // RULE11
			o_irq <= |(next_err_stat & err_mask);
		end
	end

	AST_ERR_LED_DARK: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE1
		(err_stat == '0) |=> !o_error_led)
		else $error("error led lit with no error pending");

	AST_BOOT_ERR_INIT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE2
		i_err_evt.boot |=> (comm_state == FSL_ST_INIT) && (al_change == `FSL_AL_CHANGE_ERR) &&
			err_stat[`FSL_ERR_BOOT])
		else $error("boot error did not force init and set change field");

	AST_UNSOL_CHANGE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE3
		(i_err_evt.unsol && !i_err_evt.boot && code_ok(i_unsol_state)) |=>
			(state_to_code(comm_state) == $past(i_unsol_state)) && (al_change == `FSL_AL_CHANGE_ERR))
		else $error("unsolicited change not applied or not flagged");

	AST_APP_WD_DFLASH: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE4
		(err_stat[`FSL_ERR_APP_WD] && !err_stat[`FSL_ERR_PROC_DATA_IF_WD]) |=> (o_error_led == $past(waves.dflash)))
		else $error("app watchdog not double flashing");

	AST_PROC_DATA_IF_WD_ON: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE5
		i_err_evt.proc_data_if_wd |=> ##1 o_error_led)
		else $error("process data interface watchdog did not light error led");

	AST_RUN_INIT_DARK: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE6
		(comm_state == FSL_ST_INIT) |=> !o_run_led)
		else $error("run led lit in init");

	AST_RUN_PREOP_BLINK: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE7
		(comm_state == FSL_ST_PREOP) |=> (o_run_led == $past(waves.blink)))
		else $error("run led not blinking in pre-operational");

	AST_RUN_SAFEOP_FLASH: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE8
		(comm_state == FSL_ST_SAFEOP) |=> (o_run_led == $past(waves.sflash)))
		else $error("run led not single flashing in safe-operational");

	AST_RUN_OP_ON: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE9
		(comm_state == FSL_ST_OP) [*2] |=> o_run_led)
		else $error("run led dark in operational");

	AST_RUN_FLICKER: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE10
		((comm_state == FSL_ST_STARTUP) || (comm_state == FSL_ST_BOOT)) |=> (o_run_led == $past(waves.flicker)))
		else $error("run led not flickering in start-up or bootstrap");

	AST_ALIAS_DIGITS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE11
		i_rst_b |=> (o_alias[`FSL_DIGIT_W-1:0] == $past(i_alias_low_digit_switch)) &&
			(o_alias[`FSL_ALIAS_W-1:`FSL_DIGIT_W] == $past(i_alias_high_digit_switch)))
		else $error("alias digits misplaced");

	AST_SEVERITY_ORDER: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE12
		(err_stat[`FSL_ERR_UNSOL] && err_stat[`FSL_ERR_CFG] && !err_stat[`FSL_ERR_APP_WD] &&
			!err_stat[`FSL_ERR_PROC_DATA_IF_WD]) |=> (o_error_led == $past(waves.sflash)))
		else $error("lower severity error shown over unsolicited change");

	AST_BOOT_ERR_FLICKER: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE2
		(err_stat[`FSL_ERR_BOOT] && (err_stat[`FSL_ERR_W-1:`FSL_ERR_CFG] == '0)) |=> (o_error_led == $past(waves.flicker)))
		else $error("boot error not flickering the error led");

	AST_CFG_BLINK: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE1
		(err_stat[`FSL_ERR_CFG] && (err_stat[`FSL_ERR_W-1:`FSL_ERR_UNSOL] == '0)) |=> (o_error_led == $past(waves.blink)))
		else $error("invalid configuration not blinking the error led");

	AST_UNSOL_SFLASH: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE3
		(err_stat[`FSL_ERR_UNSOL] && (err_stat[`FSL_ERR_W-1:`FSL_ERR_APP_WD] == '0)) |=> (o_error_led == $past(waves.sflash)))
		else $error("unsolicited change not single flashing the error led");

	AST_PROC_DATA_IF_WD_TOP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RULE12
		err_stat[`FSL_ERR_PROC_DATA_IF_WD] |=> o_error_led)
		else $error("most severe error not shown steadily");

endmodule : fsl_led_top

//--- pkg/fsl_consts.svh
// constants for the fieldbus status led indicator: offsets, fields, codes, timing
`ifndef FSL_CONSTS_SVH
`define FSL_CONSTS_SVH

`define FSL_ADDR_W 12
`define FSL_DATA_W 32

`define FSL_OFF_CTRL 12'h000
`define FSL_OFF_AL_STATUS 12'h004
`define FSL_OFF_ERR_STAT 12'h008
`define FSL_OFF_ERR_MASK 12'h00c
`define FSL_OFF_ALIAS 12'h010

`define FSL_ERR_W 5
`define FSL_ERR_BOOT 0
`define FSL_ERR_CFG 1
`define FSL_ERR_UNSOL 2
`define FSL_ERR_APP_WD 3
`define FSL_ERR_PROC_DATA_IF_WD 4
`define FSL_ERR_RST 5'h00
`define FSL_MASK_RST 5'h00

`define FSL_ST_CODE_W 3
`define FSL_ST_CODE_LSB 0
`define FSL_CODE_INIT 3'h0
`define FSL_CODE_PREOP 3'h1
`define FSL_CODE_SAFEOP 3'h2
`define FSL_CODE_OP 3'h3
`define FSL_CODE_BOOT 3'h4
`define FSL_CODE_STARTUP 3'h7

`define FSL_AL_CHANGE_LSB 8
`define FSL_AL_CHANGE_ERR 8'h01
`define FSL_AL_CHANGE_NONE 8'h00

`define FSL_DIGIT_W 4
`define FSL_ALIAS_W 8

`define FSL_CLK_KHZ 125000
`define FSL_TICK_MS 50
`define FSL_SEQ_W 5
`define FSL_FLASH_TICKS 5'h04
`define FSL_DFLASH2_START 5'h08
`define FSL_DFLASH2_END 5'h0c
`define FSL_BLINK_BIT 2

`endif

//--- pkg/fsl_pkg.sv
// types shared by the fieldbus status led indicator
package fsl_pkg;
`include "fsl_consts.svh"

	typedef enum logic [2:0] {
		FSL_ST_STARTUP,
		FSL_ST_INIT,
		FSL_ST_PREOP,
		FSL_ST_SAFEOP,
		FSL_ST_OP,
		FSL_ST_BOOT
	} fsl_comm_state_t;

	// bit order matches the error status register layout
	typedef struct packed {
		logic proc_data_if_wd;
		logic app_wd;
		logic unsol;
		logic cfg;
		logic boot;
	} fsl_err_evt_t;

	typedef struct packed {
		logic flicker;
		logic blink;
		logic sflash;
		logic dflash;
	} fsl_waves_t;

endpackage : fsl_pkg

//--- rtl/fsl_pattern_gen.sv
// free running blink, flicker and flash waveform generator
`timescale 1ns/1ps
`include "fsl_consts.svh"
module fsl_pattern_gen #(
	parameter int TICK_CYCLES = `FSL_TICK_MS * `FSL_CLK_KHZ
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	output fsl_pkg::fsl_waves_t o_waves
);
	import fsl_pkg::*;

	localparam int CNT_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	generate
		if (TICK_CYCLES < 2) begin : g_bad_tick
			$error("fsl_pattern_gen: TICK_CYCLES must be at least 2");
		end
	endgenerate

	logic [CNT_W-1:0] tick_cnt;
	logic [`FSL_SEQ_W-1:0] phase;
	logic tick_end;
	fsl_waves_t next_waves;

	assign tick_end = (tick_cnt == CNT_W'(TICK_CYCLES - 1));
	// flicker toggles every tick; the others share one 32 tick frame
	assign next_waves.flicker = ~phase[0];
	assign next_waves.blink = ~phase[`FSL_BLINK_BIT];
	assign next_waves.sflash = (phase < `FSL_FLASH_TICKS);
	assign next_waves.dflash = (phase < `FSL_FLASH_TICKS) ||
		((phase >= `FSL_DFLASH2_START) && (phase < `FSL_DFLASH2_END));

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tick_cnt <= '0;
			phase <= '0;
			o_waves <= '0;
		end else begin
			tick_cnt <= tick_end ? '0 : tick_cnt + 1'b1;
			phase <= tick_end ? phase + 1'b1 : phase;
			o_waves <= next_waves;
		end
	end

endmodule : fsl_pattern_gen

//--- bench/fsl_led_viewer.sv
// operator model: counts lit cycles and turn-ons of one led over one frame
`timescale 1ns/1ps
module fsl_led_viewer #(
	parameter int FR = 128
) (
	input wire logic i_sys_clk,
	input wire logic i_led
);
	// a whole frame window, so the counts do not depend on the phase
	task automatic look(output logic [31:0] o_res);
		logic prev;
		logic [15:0] on_n;
		logic [15:0] rise_n;
		on_n = '0;
		rise_n = '0;
		@(posedge i_sys_clk);
		prev = i_led;
		repeat (FR) begin
			@(posedge i_sys_clk);
			if (i_led === 1'b1) on_n++;
			if (i_led === 1'b1 && prev !== 1'b1) rise_n++;
			prev = i_led;
		end
		o_res = {on_n, rise_n};
	endtask : look
endmodule : fsl_led_viewer

//--- bench/fsl_led_top_test.sv
// self-checking bench for the fieldbus status led indicator
`timescale 1ns/1ps
`include "fsl_consts.svh"
module fsl_led_top_test;
	import fsl_pkg::*;
	localparam int TK = 4;
	localparam int FR = 32 * TK;
	localparam logic [31:0] P_OFF = 32'h0;
	localparam logic [31:0] P_ON = 32'(FR) << 16;
	localparam logic [31:0] P_FLK = (32'(FR / 2) << 16) | 32'h10;
	localparam logic [31:0] P_BLK = (32'(FR / 2) << 16) | 32'h4;
	localparam logic [31:0] P_SF = (32'(4 * TK) << 16) | 32'h1;
	localparam logic [31:0] P_DF = (32'(8 * TK) << 16) | 32'h2;
	logic [31:0] runpat [5] = '{P_OFF, P_BLK, P_SF, P_ON, P_FLK};
	logic [31:0] errpat [5] = '{P_FLK, P_BLK, P_SF, P_DF, P_ON};
	logic sys_clk = 1'b0;
	logic rst_b, psel, penable, pwrite, pready, pslverr, boot_done;
	logic error_led, run_led, irq, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, pat;
	fsl_err_evt_t err_evt;
	logic [2:0] unsol_state;
	logic [3:0] sw_lo, sw_hi;
	logic [7:0] alias_val;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;

	always #4 sys_clk = ~sys_clk;

	fsl_led_top #(.TICK_CYCLES(TK)) u_dut (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_boot_done(boot_done), .i_err_evt(err_evt),
		.i_unsol_state(unsol_state), .i_alias_low_digit_switch(sw_lo), .i_alias_high_digit_switch(sw_hi),
		.o_error_led(error_led), .o_run_led(run_led), .o_alias(alias_val), .o_irq(irq));
	fsl_led_viewer #(.FR(FR)) u_ev (.i_sys_clk(sys_clk), .i_led(error_led));
	fsl_led_viewer #(.FR(FR)) u_rv (.i_sys_clk(sys_clk), .i_led(run_led));

	task automatic complete_run;
		if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		chk("pready", 32'h1, {31'h0, pready});
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
		xfer(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask : rdc

	task automatic led(input bit run, input logic [31:0] exp);
		// let a state or status change reach the led first
		repeat (3) @(posedge sys_clk);
		if (run) u_rv.look(pat);
		else u_ev.look(pat);
		chk(run ? "run_led" : "error_led", exp, pat);
	endtask : led

	task automatic pulse(input fsl_err_evt_t e);
		@(posedge sys_clk);
		err_evt <= e;
		@(posedge sys_clk);
		err_evt <= '0;
		repeat (3) @(posedge sys_clk);
	endtask : pulse

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_mismatch++;
			complete_run();
		end
	end

	initial begin
		rst_b = 1'b0;
		{psel, penable, pwrite, boot_done} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		err_evt = '0;
		unsol_state = 3'h2;
		sw_lo = 4'h5;
		sw_hi = 4'ha;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		led(1, P_FLK);
		led(0, P_OFF);
		xfer(1'b1, `FSL_OFF_CTRL, 32'h3);
		rdc(`FSL_OFF_CTRL, 32'h7, "ctrl");
		chk("alias", 32'ha5, {24'h0, alias_val});
		rdc(`FSL_OFF_ALIAS, 32'ha5, "alias_reg");
		boot_done <= 1'b1;
		led(1, P_OFF);
		rdc(`FSL_OFF_CTRL, 32'h0, "ctrl");
		for (int s = 1; s <= 4; s++) begin
			xfer(1'b1, `FSL_OFF_CTRL, 32'(s));
			rdc(`FSL_OFF_CTRL, 32'(s), "ctrl");
			led(1, runpat[s]);
		end
		xfer(1'b1, `FSL_OFF_CTRL, 32'h5);
		rdc(`FSL_OFF_CTRL, 32'h4, "ctrl");
		rdc(`FSL_OFF_AL_STATUS, 32'h4, "al_status");
		xfer(1'b1, `FSL_OFF_ERR_MASK, 32'h1f);
		pulse(5'h01);
		rdc(`FSL_OFF_AL_STATUS, 32'h100, "al_status");
		led(0, P_FLK);
		led(1, P_OFF);
		pulse(5'h04);
		rdc(`FSL_OFF_AL_STATUS, 32'h102, "al_status");
		led(1, P_SF);
		led(0, P_SF);
		pulse(5'h1a);
		rdc(`FSL_OFF_ERR_STAT, 32'h1f, "err_stat");
		chk("irq", 32'h1, {31'h0, irq});
		// clear from the most severe down, so each level shows in turn
		for (int i = 4; i >= 0; i--) begin
			led(0, errpat[i]);
			xfer(1'b1, `FSL_OFF_ERR_STAT, 32'h1 << i);
		end
		led(0, P_OFF);
		chk("irq", 32'h0, {31'h0, irq});
		xfer(1'b1, `FSL_OFF_ERR_MASK, 32'h0);
		pulse(5'h10);
		chk("irq", 32'h0, {31'h0, irq});
		led(0, P_ON);
		xfer(1'b1, `FSL_OFF_ERR_MASK, 32'h10);
		repeat (2) @(posedge sys_clk);
		chk("irq", 32'h1, {31'h0, irq});
		xfer(1'b0, 12'h014, 32'h0);
		chk("pslverr", 32'h1, {31'h0, er});
		chk("rdata", 32'h0, rd);
		xfer(1'b1, `FSL_OFF_AL_STATUS, 32'hffff);
		rdc(`FSL_OFF_AL_STATUS, 32'h102, "al_status");
		complete_run();
	end
endmodule : fsl_led_top_test
